// File: rtl/afe_ctrl_cfg.svh
// register indices, field positions, reset values, reset time and clock rate of the control bank
`ifndef AFE_CTRL_CFG_SVH
`define AFE_CTRL_CFG_SVH

// register indices; byte address on the bus is four times the index
`define IDX_GREEN_FINE 5'h07
`define IDX_BLUE_FINE 5'h08
`define IDX_GREEN_EVEN_FINE 5'h0d
`define IDX_BLUE_EVEN_FINE 5'h0e
`define IDX_CONTROL 5'h0f
`define IDX_DELAY_IO 5'h10
`define IDX_DELAY_BLACK 5'h11
`define IDX_DELAY_VIDEO 5'h12
`define IDX_DELAY_XFER 5'h13
`define IDX_MODE 5'h14

// reset values
`define RST_FINE 10'h200
`define RST_CONTROL 8'h00
`define RST_DELAY_IO 8'h80
`define RST_DELAY_ZERO 8'h00
`define RST_MODE 8'h01

// control register field positions
`define CTL_CONV_POL 7
`define CTL_CLAMP_POL 6
`define CTL_BLACK_POL 5
`define CTL_VIDEO_POL 4
`define CTL_DLP_OFF 3
`define CTL_PWR_DOWN 2
`define CTL_BUS_DIS 1
`define CTL_GLOBAL_RST 0

// mode register field positions
`define MODE_ALTERNATE_PIXEL_OFFSET_MODE 1
`define MODE_GOM 0

// self-clear time of the global reset bit and the clock rate
`define GLOBAL_RST_NS 10
`define CLOCK_MHZ 40

`endif

// File: rtl/afe_ctrl_pkg.sv
// types shared by the front-end control bank
`default_nettype none
package afe_ctrl_pkg;

    // raw timing inputs of the front end
    typedef struct packed {
        logic conv_clock;
        logic line_clamp;
        logic black_sample;
        logic video_sample;
    } timing_pins_t;

    // every delay code handed to the analog delay lines
    typedef struct packed {
        logic [3:0] offset_gain_sample_delay;
        logic [3:0] output_data_delay;
        logic [3:0] black_lead_delay;
        logic [3:0] black_trail_delay;
        logic [3:0] video_lead_delay;
        logic [3:0] video_trail_delay;
        logic [3:0] offset_gain_transfer_delay;
        logic [3:0] conversion_clock_delay;
    } delay_codes_t;

    // fine offsets currently applied after the gain stage
    typedef struct packed {
        logic [9:0] green_fine_offset_field;
        logic [9:0] blue_fine_offset_field;
    } fine_offsets_t;

    // decoded register address
    typedef struct packed {
        logic hit;
        logic [4:0] index;
    } reg_decode_t;

endpackage
`default_nettype wire

// File: rtl/afe_ctrl_regs.sv
// control, polarity, fine-offset and delay register bank of the imaging front end
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "afe_ctrl_cfg.svh"

// Functional notes
// - green even fine offset, 1 mV steps
// - blue even fine offset, 10-bit, mid-scale default
// - control bits D7..D0, all default zero
// - each timing input has own polarity bit
// - conversion clock polarity bit inverts internal clock
// - clamp active high at 0, odd from fall
// - black polarity selects sampling edge
// - video polarity selects sampling edge
// - power-down bit enters low-power state
// - bus-disable bit floats conversion output bus
// - global reset restores defaults, self-clears
// - upper first delay nibble: offset/gain sample
// - lower first delay nibble: output data delay
// - black pulse leading edge delay code
// - black pulse trailing edge delay code
// - video pulse leading edge delay code
// - video pulse trailing edge delay code
// - offset/gain transfer pulse delay code
// - conversion clock delay code
// - alternate mode needs its bit, gain mode clear
module afe_ctrl_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [6:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // timing inputs from the pins
    input wire afe_ctrl_pkg::timing_pins_t timing_pins,
    // polarity-corrected internal timing
    output logic conv_clock_int,
    output logic line_clamp_active,
    output logic black_sample_take,
    output logic video_sample_take,
    output logic odd_pixel,
    // operating state
    output logic power_down,
    output logic dynamic_low_power_off,
    output logic conv_output_bus_enable,
    output afe_ctrl_pkg::fine_offsets_t fine_offsets,
    output afe_ctrl_pkg::delay_codes_t delay_codes
);

    // global reset self-clear time as a cycle count, never below one cycle
    localparam int RST_CYC_RAW = (`GLOBAL_RST_NS * `CLOCK_MHZ) / 1000;
    localparam int RST_CYC = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
    localparam logic [3:0] RST_CYC_W = 4'(RST_CYC);

    // decode a byte address into a register index; misaligned or unmapped misses
    function automatic afe_ctrl_pkg::reg_decode_t decode(input logic [6:0] addr);
        afe_ctrl_pkg::reg_decode_t d;
        d.index = addr[6:2];
        case (addr[6:2])
            `IDX_GREEN_FINE, `IDX_BLUE_FINE, `IDX_GREEN_EVEN_FINE, `IDX_BLUE_EVEN_FINE,
            `IDX_CONTROL, `IDX_DELAY_IO, `IDX_DELAY_BLACK, `IDX_DELAY_VIDEO,
            `IDX_DELAY_XFER, `IDX_MODE: begin
                d.hit = (addr[1:0] == 2'h0);
            end
            default: begin
                d.hit = 1'b0;
            end
        endcase
        return d;
    endfunction

    // merge a 10-bit field with write data under the two low byte lanes
    function automatic logic [9:0] merge10(input logic [9:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
        logic [9:0] m;
        m = old;
        if (be[0]) begin
            m[7:0] = wd[7:0];
        end
        if (be[1]) begin
            m[9:8] = wd[9:8];
        end
        return m;
    endfunction

    // bus handshake state
    logic wait_ff; // waitrequest, high until the slave answers
    logic [31:0] rdata_ff; // read data captured when the answer is given

    // register storage
    logic [9:0] green_fine_ff; // ordinary green fine offset
    logic [9:0] blue_fine_ff; // ordinary blue fine offset
    logic [9:0] green_even_fine_ff; // green even-pixel fine offset
    logic [9:0] blue_even_fine_ff; // blue even-pixel fine offset
    logic [7:0] control_ff; // control / polarity bits
    logic [7:0] delay_io_ff; // offset/gain sample and output data delays
    logic [7:0] delay_black_ff; // black pulse edge delays
    logic [7:0] delay_video_ff; // video pulse edge delays
    logic [7:0] delay_xfer_ff; // transfer pulse and conversion clock delays
    logic [7:0] mode_ff; // mode bits, of which two steer this block
    logic [3:0] rst_cnt_ff; // cycles left before the global reset bit clears

    // pin synchronisers and edge history
    afe_ctrl_pkg::timing_pins_t pins_meta_ff; // first stage, read only by the second
    afe_ctrl_pkg::timing_pins_t pins_sync_ff; // second stage
    logic clamp_act_d_ff; // previous clamp activity
    logic black_act_d_ff; // previous black sample activity
    logic video_act_d_ff; // previous video sample activity

    // output flops
    logic conv_int_ff;
    logic clamp_act_ff;
    logic black_take_ff;
    logic video_take_ff;
    logic odd_ff;
    logic bus_en_ff;
    afe_ctrl_pkg::fine_offsets_t offs_ff;

    // combinational helpers
    afe_ctrl_pkg::reg_decode_t dec; // decode of the current address
    logic wr_hit; // write accepted this edge
    logic soft_rst; // global reset is clearing the bank this edge
    logic [31:0] nxt_rdata; // read value of the addressed register
    logic clamp_act; // clamp activity after polarity
    logic black_act; // black sample activity after polarity
    logic video_act; // video sample activity after polarity
    logic alt_mode; // alternate pixel offset mode in force

    assign dec = decode(address);
    // a write takes effect only at the edge where waitrequest is seen low
    assign wr_hit = write && !wait_ff && dec.hit;
    // defaults load while the reset bit stands and its count has run out
    // at this clock rate the short self-clear time rounds up to one whole cycle,
    // so a read right after the write may still see the reset bit set
    assign soft_rst = control_ff[`CTL_GLOBAL_RST] && (rst_cnt_ff <= 4'h1);

    // read multiplexer; the unused upper bits come back as zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (dec.hit) begin
            case (dec.index)
                `IDX_GREEN_FINE: nxt_rdata[9:0] = green_fine_ff;
                `IDX_BLUE_FINE: nxt_rdata[9:0] = blue_fine_ff;
                `IDX_GREEN_EVEN_FINE: nxt_rdata[9:0] = green_even_fine_ff;
                `IDX_BLUE_EVEN_FINE: nxt_rdata[9:0] = blue_even_fine_ff;
                `IDX_CONTROL: nxt_rdata[7:0] = control_ff;
                `IDX_DELAY_IO: nxt_rdata[7:0] = delay_io_ff;
                `IDX_DELAY_BLACK: nxt_rdata[7:0] = delay_black_ff;
                `IDX_DELAY_VIDEO: nxt_rdata[7:0] = delay_video_ff;
                `IDX_DELAY_XFER: nxt_rdata[7:0] = delay_xfer_ff;
                `IDX_MODE: nxt_rdata[7:0] = mode_ff;
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // bus handshake: one wait cycle, then the answer for exactly one edge
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else if ((read || write) && wait_ff) begin
            // answer now; read data stands at the edge the master takes it
            wait_ff <= 1'b0;
            rdata_ff <= nxt_rdata;
        end else begin
            wait_ff <= 1'b1;
        end
    end

    // fine offset registers; the global reset returns them to mid-scale
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            green_fine_ff <= `RST_FINE;
            blue_fine_ff <= `RST_FINE;
            green_even_fine_ff <= `RST_FINE;
            blue_even_fine_ff <= `RST_FINE;
        end else if (soft_rst) begin
            green_fine_ff <= `RST_FINE;
            blue_fine_ff <= `RST_FINE;
            green_even_fine_ff <= `RST_FINE;
            blue_even_fine_ff <= `RST_FINE;
        end else if (wr_hit) begin
            case (dec.index)
                `IDX_GREEN_FINE: green_fine_ff <= merge10(green_fine_ff, writedata, byteenable);
                `IDX_BLUE_FINE: blue_fine_ff <= merge10(blue_fine_ff, writedata, byteenable);
                `IDX_GREEN_EVEN_FINE: begin
                    green_even_fine_ff <= merge10(green_even_fine_ff, writedata, byteenable);
                end
                `IDX_BLUE_EVEN_FINE: begin
                    blue_even_fine_ff <= merge10(blue_even_fine_ff, writedata, byteenable);
                end
                default: begin
                    // other registers are handled by their own processes
                end
            endcase
        end
    end

    // control register and the self-clearing global reset bit
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            control_ff <= `RST_CONTROL;
            rst_cnt_ff <= 4'h0;
        end else if (soft_rst) begin
            // the reset bit clears itself together with everything else
            control_ff <= `RST_CONTROL;
            rst_cnt_ff <= 4'h0;
        end else if (control_ff[`CTL_GLOBAL_RST]) begin
            // writes are held off while the reset runs out its time
            rst_cnt_ff <= rst_cnt_ff - 4'h1;
        end else if (wr_hit && dec.index == `IDX_CONTROL && byteenable[0]) begin
            control_ff <= writedata[7:0];
            if (writedata[`CTL_GLOBAL_RST]) begin
                rst_cnt_ff <= RST_CYC_W;
            end
        end
    end

    // delay registers; only the low byte lane carries any bits
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            delay_io_ff <= `RST_DELAY_IO;
            delay_black_ff <= `RST_DELAY_ZERO;
            delay_video_ff <= `RST_DELAY_ZERO;
            delay_xfer_ff <= `RST_DELAY_ZERO;
        end else if (soft_rst) begin
            delay_io_ff <= `RST_DELAY_IO;
            delay_black_ff <= `RST_DELAY_ZERO;
            delay_video_ff <= `RST_DELAY_ZERO;
            delay_xfer_ff <= `RST_DELAY_ZERO;
        end else if (wr_hit && byteenable[0]) begin
            case (dec.index)
                `IDX_DELAY_IO: delay_io_ff <= writedata[7:0];
                `IDX_DELAY_BLACK: delay_black_ff <= writedata[7:0];
                `IDX_DELAY_VIDEO: delay_video_ff <= writedata[7:0];
                `IDX_DELAY_XFER: delay_xfer_ff <= writedata[7:0];
                default: begin
                    // not a delay register
                end
            endcase
        end
    end

    // mode register; only the alternate offset and gain mode bits act here
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mode_ff <= `RST_MODE;
        end else if (soft_rst) begin
            mode_ff <= `RST_MODE;
        end else if (wr_hit && dec.index == `IDX_MODE && byteenable[0]) begin
            mode_ff <= writedata[7:0];
        end
    end

    // two-stage synchroniser on every timing pin
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pins_meta_ff <= '0;
            pins_sync_ff <= '0;
        end else begin
            pins_meta_ff <= timing_pins;
            pins_sync_ff <= pins_meta_ff;
        end
    end

    // polarity correction: each input is xor-ed with its own polarity bit
    assign clamp_act = pins_sync_ff.line_clamp ^ control_ff[`CTL_CLAMP_POL];
    assign black_act = pins_sync_ff.black_sample ^ control_ff[`CTL_BLACK_POL];
    assign video_act = pins_sync_ff.video_sample ^ control_ff[`CTL_VIDEO_POL];

    // edge history of the corrected activity levels
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clamp_act_d_ff <= 1'b0;
            black_act_d_ff <= 1'b0;
            video_act_d_ff <= 1'b0;
        end else begin
            clamp_act_d_ff <= clamp_act;
            black_act_d_ff <= black_act;
            video_act_d_ff <= video_act;
        end
    end

    // internal timing outputs; sample pulses are quiet in power-down
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            conv_int_ff <= 1'b0;
            clamp_act_ff <= 1'b0;
            black_take_ff <= 1'b0;
            video_take_ff <= 1'b0;
        end else begin
            // inverted clock is high while the conversion clock pin is low
            conv_int_ff <= pins_sync_ff.conv_clock ^ control_ff[`CTL_CONV_POL];
            clamp_act_ff <= clamp_act;
            // end of the active level is the falling edge at polarity 0, rising at 1
            black_take_ff <= black_act_d_ff && !black_act
                             && !control_ff[`CTL_PWR_DOWN];
            video_take_ff <= video_act_d_ff && !video_act
                             && !control_ff[`CTL_PWR_DOWN];
        end
    end

    // pixel parity: the end of clamping marks the next pixel odd, each video sample flips it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            odd_ff <= 1'b1;
        end else if (clamp_act_d_ff && !clamp_act) begin
            odd_ff <= 1'b1;
        end else if (video_act_d_ff && !video_act) begin
            odd_ff <= !odd_ff;
        end
    end

    // alternate offset mode only counts with fixed gain/offset operation
    assign alt_mode = mode_ff[`MODE_ALTERNATE_PIXEL_OFFSET_MODE] && !mode_ff[`MODE_GOM];

    // applied fine offsets: even registers on even pixels in alternate mode
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            offs_ff <= {`RST_FINE, `RST_FINE};
        end else if (alt_mode && !odd_ff) begin
            offs_ff.green_fine_offset_field <= green_even_fine_ff;
            offs_ff.blue_fine_offset_field <= blue_even_fine_ff;
        end else begin
            offs_ff.green_fine_offset_field <= green_fine_ff;
            offs_ff.blue_fine_offset_field <= blue_fine_ff;
        end
    end

    // output bus enable follows the disable bit
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bus_en_ff <= 1'b1;
        end else begin
            bus_en_ff <= !control_ff[`CTL_BUS_DIS];
        end
    end

    // outputs
    assign readdata = rdata_ff;
    assign waitrequest = wait_ff;
    assign conv_clock_int = conv_int_ff;
    assign line_clamp_active = clamp_act_ff;
    assign black_sample_take = black_take_ff;
    assign video_sample_take = video_take_ff;
    assign odd_pixel = odd_ff;
    assign power_down = control_ff[`CTL_PWR_DOWN];
    assign dynamic_low_power_off = control_ff[`CTL_DLP_OFF];
    assign conv_output_bus_enable = bus_en_ff;
    assign fine_offsets = offs_ff;
    // delay codes drive the analog delay lines straight from the registers
    assign delay_codes.offset_gain_sample_delay = delay_io_ff[7:4];
    assign delay_codes.output_data_delay = delay_io_ff[3:0];
    assign delay_codes.black_lead_delay = delay_black_ff[7:4];
    assign delay_codes.black_trail_delay = delay_black_ff[3:0];
    assign delay_codes.video_lead_delay = delay_video_ff[7:4];
    assign delay_codes.video_trail_delay = delay_video_ff[3:0];
    assign delay_codes.offset_gain_transfer_delay = delay_xfer_ff[7:4];
    assign delay_codes.conversion_clock_delay = delay_xfer_ff[3:0];

endmodule

`default_nettype wire

// File: tb/afe_timing_gen.sv
// timing generator model that drives the front end's timing pins
`timescale 1ns/1ps
`default_nettype none
module afe_timing_gen (
    // clock
    input wire logic clock,
    // timing pins toward the front end
    output var afe_ctrl_pkg::timing_pins_t pins
);
    // pins rest low, the level their pull-downs give them
    initial begin
        pins = '0;
    end
    // move one pin just after an edge, then hold it; the level lasts one cycle more than the hold
    task automatic drive(input int idx, input logic lvl, input int hold);
        @(posedge clock);
        pins[idx] <= lvl;
        repeat (hold) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// File: tb/afe_ctrl_regs_chk.sv
// port assertions of the control register bank
`timescale 1ns/1ps
`default_nettype none
`include "afe_ctrl_cfg.svh"
module afe_ctrl_regs_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // register bus
    input wire logic [6:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // pins and decoded state
    input wire afe_ctrl_pkg::timing_pins_t timing_pins,
    input wire logic conv_clock_int,
    input wire logic line_clamp_active,
    input wire logic black_sample_take,
    input wire logic video_sample_take,
    input wire logic power_down,
    input wire logic dynamic_low_power_off,
    input wire logic conv_output_bus_enable,
    input wire afe_ctrl_pkg::delay_codes_t delay_codes
);
    logic wr_done; // aligned low-lane write lands at this edge
    logic [7:0] ctl_ff; // shadow of the control byte
    assign wr_done = write && !waitrequest && address[1:0] == 2'b00 && byteenable[0];
    // a pending global reset wins over a new write, as in the bank itself
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctl_ff <= 8'h00;
        end else if (ctl_ff[0]) begin
            ctl_ff <= 8'h00;
        end else if (wr_done && address[6:2] == `IDX_CONTROL) begin
            ctl_ff <= writedata[7:0];
        end
    end
    // delay byte fed by a register index, first delay register in the top byte
    function automatic logic [7:0] dly_pick(afe_ctrl_pkg::delay_codes_t d, logic [1:0] s);
        return d[8 * (3 - s) +: 8];
    endfunction
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer is not one wait cycle");
    chk_read_upper: assert property (read && !waitrequest |-> readdata[31:10] == 22'h0
        && (address[6:2] < `IDX_CONTROL || readdata[9:8] == 2'h0))
        else $error("unused read bits not zero");
    chk_conv_pol: assert property ($stable({timing_pins.conv_clock, ctl_ff[7]}) [*4]
        |-> conv_clock_int == (timing_pins.conv_clock ^ ctl_ff[7]))
        else $error("conversion clock polarity wrong");
    chk_clamp_pol: assert property ($stable({timing_pins.line_clamp, ctl_ff[6]}) [*4]
        |-> line_clamp_active == (timing_pins.line_clamp ^ ctl_ff[6]))
        else $error("line clamp polarity wrong");
    chk_take_pulse: assert property (!(black_sample_take && $past(black_sample_take))
        && !(video_sample_take && $past(video_sample_take)))
        else $error("sample pulse longer than one cycle");
    chk_pd_quiet: assert property (power_down && $past(power_down)
        |-> !black_sample_take && !video_sample_take)
        else $error("sample pulse while powered down");
    chk_pwr_bits: assert property ($stable(ctl_ff[3:2]) [*2]
        |-> power_down == ctl_ff[2] && dynamic_low_power_off == ctl_ff[3])
        else $error("power bits do not follow control");
    chk_bus_enable: assert property (conv_output_bus_enable == !$past(ctl_ff[1]))
        else $error("output bus enable wrong");
    chk_dly_write: assert property (wr_done && address[6:4] == 3'h4 && !ctl_ff[0]
        |=> dly_pick(delay_codes, $past(address[3:2])) == $past(writedata[7:0]))
        else $error("delay codes do not follow write");
    chk_global_rst: assert property (wr_done && address[6:2] == `IDX_CONTROL
        && writedata[0] |=> ##1 delay_codes == 32'h8000_0000)
        else $error("global reset left delays changed");
endmodule
bind afe_ctrl_regs afe_ctrl_regs_chk u_chk (.clock(clock), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .timing_pins(timing_pins),
    .conv_clock_int(conv_clock_int), .line_clamp_active(line_clamp_active),
    .black_sample_take(black_sample_take), .video_sample_take(video_sample_take),
    .power_down(power_down), .dynamic_low_power_off(dynamic_low_power_off),
    .conv_output_bus_enable(conv_output_bus_enable), .delay_codes(delay_codes));
`default_nettype wire

// File: tb/afe_ctrl_regs_bench.sv
// self-checking bench of the control register bank
`timescale 1ns/1ps
`default_nettype none
module afe_ctrl_regs_bench;
    logic clock = 1'b0; // 40 mhz
    logic rstn = 1'b0;
    logic [6:0] address = 7'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'h3; // both lanes always
    logic [31:0] readdata, rd_val;
    logic waitrequest, conv_int, clamp_act, black_take, video_take, odd, pd, dlp_off, bus_en;
    afe_ctrl_pkg::timing_pins_t pins;
    afe_ctrl_pkg::fine_offsets_t fine;
    afe_ctrl_pkg::delay_codes_t dly;
    int err_count = 0;
    int n_tests = 0;
    int n_black = 0; // sample pulses seen
    int n_video = 0;
    logic [6:0] adr [7] = '{7'h34, 7'h38, 7'h3c, 7'h40, 7'h44, 7'h48, 7'h4c};
    logic [31:0] dflt [7] = '{32'h200, 32'h200, 32'h0, 32'h80, 32'h0, 32'h0, 32'h0};
    // clock of 25 ns
    always #12.5 clock = ~clock;
    // count sample pulses as they appear
    always @(posedge clock) begin
        n_black += int'(black_take === 1'b1);
        n_video += int'(video_take === 1'b1);
    end
    afe_timing_gen gen (.clock(clock), .pins(pins));
    afe_ctrl_regs dut (.clock(clock), .rstn(rstn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .timing_pins(pins), .conv_clock_int(conv_int),
        .line_clamp_active(clamp_act), .black_sample_take(black_take),
        .video_sample_take(video_take), .odd_pixel(odd), .power_down(pd),
        .dynamic_low_power_off(dlp_off), .conv_output_bus_enable(bus_en),
        .fine_offsets(fine), .delay_codes(dly));
    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one bus transfer; one idle edge first so a strobe is never set twice in a step
    task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rd_val = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 20) begin
            err_count++;
            tally_and_finish();
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), rd_val, exp);
    endtask
    // one active pulse: no take while active, exactly one at its end
    task automatic edge_test(input int idx, input logic pol);
        n_black = 0;
        n_video = 0;
        gen.drive(idx, !pol, 4);
        check("early takes", 32'(n_black + n_video), 32'h0);
        gen.drive(idx, pol, 6);
        check("black takes", 32'(n_black), 32'(idx == 1));
        check("video takes", 32'(n_video), 32'(idx == 0));
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(adr[i], dflt[i]);
        end
        check("delays", dly, 32'h8000_0000);
        check("bus enable", 32'(bus_en), 32'h1);
        // every bit set except bit 0, the self-clearing reset in the control register and clear in the other six
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, adr[i], 32'hffff_fffe);
            rd(adr[i], i < 2 ? 32'h3fe : 32'hfe);
        end
        check("delays", dly, 32'hfefe_fefe);
        check("power down", 32'(pd), 32'h1);
        check("dlp off", 32'(dlp_off), 32'h1);
        check("bus enable", 32'(bus_en), 32'h0);
        bus(1'b1, 7'h60, 32'h3ff);
        rd(7'h60, 32'h0);
        rd(7'h3e, 32'h0);
        // all polarities inverted
        gen.drive(3, 1'b1, 5);
        check("conv clock", 32'(conv_int), 32'h0);
        check("clamp", 32'(clamp_act), 32'h1);
        n_black = 0;
        n_video = 0;
        gen.drive(1, 1'b1, 2);
        gen.drive(0, 1'b1, 6);
        check("takes in power down", 32'(n_black + n_video), 32'h0);
        bus(1'b1, 7'h3c, 32'h30);
        rd(7'h3c, 32'h30);
        check("bus enable", 32'(bus_en), 32'h1);
        check("conv clock", 32'(conv_int), 32'h1);
        edge_test(1, 1'b1);
        edge_test(0, 1'b1);
        // pins stay high, so dropping the polarity makes them active, never ends an activity
        bus(1'b1, 7'h3c, 32'h0);
        edge_test(1, 1'b0);
        edge_test(0, 1'b0);
        // alternate pixel offsets
        bus(1'b1, 7'h1c, 32'h111);
        bus(1'b1, 7'h20, 32'h122);
        bus(1'b1, 7'h34, 32'h2aa);
        bus(1'b1, 7'h38, 32'h255);
        bus(1'b1, 7'h50, 32'h2);
        gen.drive(2, 1'b1, 3);
        gen.drive(2, 1'b0, 6);
        check("odd pixel", 32'(odd), 32'h1);
        check("offsets", {12'h0, fine}, {12'h0, 10'h111, 10'h122});
        gen.drive(0, 1'b1, 3);
        gen.drive(0, 1'b0, 6);
        check("odd pixel", 32'(odd), 32'h0);
        check("offsets", {12'h0, fine}, {12'h0, 10'h2aa, 10'h255});
        bus(1'b1, 7'h50, 32'h3);
        rd(7'h50, 32'h3);
        check("offsets", {12'h0, fine}, {12'h0, 10'h111, 10'h122});
        // global reset restores defaults and clears itself
        bus(1'b1, 7'h3c, 32'h1);
        rd(7'h3c, 32'h0);
        rd(7'h50, 32'h1);
        rd(7'h34, 32'h200);
        check("delays", dly, 32'h8000_0000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
